// [include/core_sfr_pkg.sv]
/*
 * Constants of the core SFR block: offsets, fields and reset values.
 * Assumes one clock domain and an 8-bit SFR data path.
 */
package core_sfr_pkg;

    // Direct SFR addresses.
    localparam logic [7:0] ADDR_PORT0_LATCH = 8'h80;
    localparam logic [7:0] ADDR_STACK_TOP = 8'h81;
    localparam logic [7:0] ADDR_POINTER0_LOW = 8'h82;
    localparam logic [7:0] ADDR_POINTER0_HIGH = 8'h83;
    localparam logic [7:0] ADDR_POINTER1_LOW = 8'h84;
    localparam logic [7:0] ADDR_POINTER1_HIGH = 8'h85;
    localparam logic [7:0] ADDR_POINTER_SELECT = 8'h86;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] ADDR_PORT4_CHIPSEL_CFG = 8'hA2;
    localparam logic [7:0] ADDR_POWER_MGMT = 8'hC4;
    localparam logic [7:0] SFR_BASE = 8'h80;

    // Field positions.
    localparam int POS_SELECT = 0;
    localparam int POS_BAUD_DOUBLE = 7;
    localparam int POS_FRAME_ERR_EN = 6;
    localparam int POS_USER_FLAG_HI = 3;
    localparam int POS_USER_FLAG_LO = 2;
    localparam int POS_POWERDOWN = 1;
    localparam int POS_IDLE = 0;
    localparam int POS_XRAM_EN = 0;
    localparam int POS_ECON_LO = 6;
    localparam int POS_PULLUP = 0;

    // Reset values and masks.
    localparam logic [7:0] RST_PORT0_LATCH = 8'hFF;
    localparam logic [7:0] RST_STACK_TOP = 8'h07;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] MASK_POWER_CONTROL = 8'hCF;
    localparam logic [7:0] MASK_POWER_MGMT = 8'hC1;
    localparam logic [7:0] MASK_PULLUP = 8'h01;
    localparam logic [7:0] UNIMPL_READ = 8'hFF;

    // On-chip data SRAM window.
    localparam int XRAM_BYTES = 1024;
    localparam logic [15:0] XRAM_LAST = 16'h03FF;

    // Economy divider settings: 4, 64 or 1024.
    localparam int ECON_DIV_4 = 4;
    localparam int ECON_DIV_64 = 64;
    localparam int ECON_DIV_1024 = 1024;

    typedef enum logic [1:0] {
        econ_off,
        econ_4,
        econ_64,
        econ_1024
    } econ_mode_e;

    typedef enum {
        pwr_run,
        pwr_idle,
        pwr_down
    } pwr_state_e;

endpackage

// [rtl/econ_divider.sv]
/*
 * Economy divider: a one-cycle tick every 1, 4, 64 or 1024 clocks.
 * Assumes the consumer gates work with the tick, not a new clock.
 */
`timescale 1ns/1ps

module econ_divider
    import core_sfr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Control.
    input wire econ_mode_e mode,
    // Result.
    output logic tick
);

    logic [9:0] count;
    logic [9:0] last;

    always_comb begin
        case (mode)
            econ_4: last = 10'(ECON_DIV_4 - 1);
            econ_64: last = 10'(ECON_DIV_64 - 1);
            econ_1024: last = 10'(ECON_DIV_1024 - 1);
            default: last = 10'h000;
        endcase
    end

    // Wrapping on >= copes with a switch to a shorter period.
    always_ff @(posedge clk) begin
        if (rst || count >= last) begin
            count <= 10'h000;
        end else begin
            count <= count + 10'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tick <= 1'b0;
        end else begin
            tick <= (count >= last);
        end
    end

endmodule

// [rtl/xram_store.sv]
/*
 * On-chip 1 KB data SRAM for external-data moves.
 * Assumes the caller has decided the access hits it.
 */
`timescale 1ns/1ps

module xram_store
    import core_sfr_pkg::*;
#(
    parameter int DEPTH = XRAM_BYTES
)
(
    // Clock.
    input wire logic clk,
    // Access.
    input wire logic wr,
    input wire logic [$clog2(DEPTH)-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);

    logic [7:0] mem [DEPTH];

    if (DEPTH < 2) begin
        $error("xram_store depth too small");
    end

    always_ff @(posedge clk) begin
        if (wr) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule

// [rtl/core_sfr.sv]
/*
 * Core SFR bank: SFR access, dual pointer, stack top, power modes,
 * data-move routing and the economy divider.
 * Assumes one SFR access and one data move per cycle from the core.
 */
`timescale 1ns/1ps

// Contract
// R1: Economy mode divides clock by 4/64/1024.
// R2: Idle stops CPU clock, peripherals keep running.
// R3: Power-down stops every internal clock.
// R4: 1 KB data SRAM at 0000H-03FFH.
// R5: Reset clears SRAM enable; all moves external.
// R6: Enabled: up to 03FFH on-chip, above external.
// R7: No instruction fetch from data SRAM.
// R8: Scratchpad and data SRAM never alias.
// R9: Code space up to 64 KB, separate.
// R10: SFRs 80h-FFh, direct addressing only.
// R11: Bit access only at addresses ending 0/8.
// R12: Unimplemented SFR locations and bits read ones.
// R13: Select bit chooses second pointer pair.
// R14: Select bits 1-7 read zero.
// R15: Second pointer bytes are plain storage too.
// R16: Stack top holds scratchpad top address.
// R17: Port 0 pull-ups follow enable bit at A2H.
// R18: Power control bit 7 doubles baud rate.
// R19: Frame-error enable repurposes serial bit 7.
// R20: Power control bits 3,2 are user flags.
// R21: Interrupt/reset leave idle; reset/ext int wake.
module core_sfr
    import core_sfr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Direct SFR access from the core.
    input wire logic sfr_direct,
    input wire logic sfr_rd,
    input wire logic sfr_wr,
    input wire logic sfr_bit,
    input wire logic [2:0] sfr_bit_pos,
    input wire logic sfr_bit_val,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_bit_rdata,
    // Pointer and stack updates from the core.
    input wire logic ptr_load,
    input wire logic [15:0] ptr_load_val,
    input wire logic ptr_inc,
    input wire logic ptr_dec,
    input wire logic stack_load,
    input wire logic [7:0] stack_load_val,
    output logic [15:0] active_pointer,
    output logic [7:0] stack_top,
    // Data move and code fetch requests.
    input wire logic move_req,
    input wire logic move_wr,
    input wire logic [15:0] move_addr,
    input wire logic [7:0] move_wdata,
    input wire logic code_req,
    input wire logic [15:0] code_addr,
    output logic move_onchip,
    output logic move_ext_req,
    output logic move_ext_wr,
    output logic [15:0] move_ext_addr,
    output logic [7:0] move_ext_wdata,
    output logic [7:0] move_onchip_rdata,
    output logic code_ext_req,
    output logic [15:0] code_ext_addr,
    // Wake events.
    input wire logic int_enabled_pending,
    input wire logic ext_int_enabled_pending,
    // Power and peripheral controls.
    output logic cpu_clk_run,
    output logic periph_clk_run,
    output logic econ_tick,
    output logic baud_double,
    output logic frame_err_enable,
    output logic port0_pullup_enable,
    output logic onchip_xram_enable
);
    logic [7:0] port0_latch;
    logic [7:0] pointer0_low;
    logic [7:0] pointer0_high;
    logic [7:0] pointer1_low;
    logic [7:0] pointer1_high;
    logic pointer_select;
    logic [7:0] power_control_reg;
    logic [7:0] power_mgmt_reg;
    logic [7:0] port4_chipsel_cfg;
    pwr_state_e pwr_state;
    pwr_state_e next_pwr_state;
    logic [7:0] read_value;
    logic [7:0] write_value;
    logic [15:0] next_pointer;
    logic hit_onchip;
    logic xram_rd_pending;
    logic [7:0] xram_rdata;
    logic div_tick;
    // Merges a single-bit write into the current byte.
    function automatic logic [7:0] merge_bit(input logic [7:0] cur, input logic [2:0] pos,
                                             input logic val);
        merge_bit = cur;
        merge_bit[pos] = val;
    endfunction
    // A location allows bit access only when its low nibble is 0 or 8.
    function automatic logic bit_capable(input logic [7:0] addr);
        return addr[2:0] == 3'h0;  // [R11]
    endfunction
    // Only direct accesses in the upper half reach the SFR space.
    logic sfr_sel;
    logic sfr_write;
    assign sfr_sel = sfr_direct && (sfr_addr >= SFR_BASE);  // [R10]
    assign sfr_write = sfr_sel && sfr_wr && (!sfr_bit || bit_capable(sfr_addr));  // [R11]
    always_comb begin
        case (sfr_addr)
            ADDR_PORT0_LATCH: read_value = port0_latch;
            ADDR_STACK_TOP: read_value = stack_top;
            ADDR_POINTER0_LOW: read_value = pointer0_low;
            ADDR_POINTER0_HIGH: read_value = pointer0_high;
            ADDR_POINTER1_LOW: read_value = pointer1_low;
            ADDR_POINTER1_HIGH: read_value = pointer1_high;
            ADDR_POINTER_SELECT: read_value = {7'h00, pointer_select};  // [R14]
            ADDR_POWER_CONTROL: read_value = power_control_reg | ~MASK_POWER_CONTROL;  // [R12]
            ADDR_POWER_MGMT: read_value = power_mgmt_reg | ~MASK_POWER_MGMT;  // [R12]
            ADDR_PORT4_CHIPSEL_CFG: read_value = port4_chipsel_cfg | ~MASK_PULLUP;  // [R12]
            default: read_value = UNIMPL_READ;  // [R12]
        endcase
    end
    assign write_value = sfr_bit ? merge_bit(read_value, sfr_bit_pos, sfr_bit_val) : sfr_wdata;
    always_ff @(posedge clk) begin
        if (rst) begin
            sfr_rdata <= UNIMPL_READ;
            sfr_bit_rdata <= 1'b1;
        end else if (sfr_sel && sfr_rd) begin
            sfr_rdata <= read_value;
            sfr_bit_rdata <= bit_capable(sfr_addr) ? read_value[sfr_bit_pos] : 1'b1;  // [R11]
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            port0_latch <= RST_PORT0_LATCH;
        end else if (sfr_write && sfr_addr == ADDR_PORT0_LATCH) begin
            port0_latch <= write_value;
        end
    end
    // The stack top is a scratchpad address, so it is only 8 bits wide.
    always_ff @(posedge clk) begin
        if (rst) begin
            stack_top <= RST_STACK_TOP;
        end else if (sfr_write && sfr_addr == ADDR_STACK_TOP) begin
            stack_top <= write_value;  // [R16]
        end else if (stack_load) begin
            stack_top <= stack_load_val;  // [R16]
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            pointer_select <= 1'b0;
        end else if (sfr_write && sfr_addr == ADDR_POINTER_SELECT) begin
            pointer_select <= write_value[POS_SELECT];  // [R13]
        end
    end
    always_comb begin
        if (ptr_load) begin
            next_pointer = ptr_load_val;
        end else if (ptr_inc) begin
            next_pointer = active_pointer + 16'h0001;
        end else if (ptr_dec) begin
            next_pointer = active_pointer - 16'h0001;
        end else begin
            next_pointer = active_pointer;
        end
    end
    logic ptr_update;
    assign ptr_update = ptr_load || ptr_inc || ptr_dec;
    always_ff @(posedge clk) begin
        if (rst) begin
            pointer0_low <= RST_ZERO;
            pointer0_high <= RST_ZERO;
        end else if (sfr_write && sfr_addr == ADDR_POINTER0_LOW) begin
            pointer0_low <= write_value;
        end else if (sfr_write && sfr_addr == ADDR_POINTER0_HIGH) begin
            pointer0_high <= write_value;
        end else if (ptr_update && !pointer_select) begin
            {pointer0_high, pointer0_low} <= next_pointer;  // [R13]
        end
    end
    // Untouched by pointer instructions unless selected, so it serves as storage.
    always_ff @(posedge clk) begin
        if (rst) begin
            pointer1_low <= RST_ZERO;
            pointer1_high <= RST_ZERO;
        end else if (sfr_write && sfr_addr == ADDR_POINTER1_LOW) begin
            pointer1_low <= write_value;  // [R15]
        end else if (sfr_write && sfr_addr == ADDR_POINTER1_HIGH) begin
            pointer1_high <= write_value;  // [R15]
        end else if (ptr_update && pointer_select) begin
            {pointer1_high, pointer1_low} <= next_pointer;  // [R13]
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            active_pointer <= 16'h0000;
        end else begin
            active_pointer <= pointer_select ? {pointer1_high, pointer1_low}
                                             : {pointer0_high, pointer0_low};  // [R13]
        end
    end
    // Wake events clear the mode bits; a set in the same cycle loses to them.
    always_ff @(posedge clk) begin
        if (rst) begin
            power_control_reg <= RST_ZERO;  // [R21]
        end else begin
            if (sfr_write && sfr_addr == ADDR_POWER_CONTROL) begin
                power_control_reg <= write_value & MASK_POWER_CONTROL;  // [R20]
            end
            if (pwr_state == pwr_idle && int_enabled_pending) begin
                power_control_reg[POS_IDLE] <= 1'b0;  // [R21]
            end
            if (pwr_state == pwr_down && ext_int_enabled_pending) begin
                power_control_reg[POS_POWERDOWN] <= 1'b0;  // [R21]
                power_control_reg[POS_IDLE] <= 1'b0;  // [R21]
            end
        end
    end
    always_comb begin
        case (pwr_state)
            pwr_run: begin
                if (power_control_reg[POS_POWERDOWN]) begin
                    next_pwr_state = pwr_down;  // [R3]
                end else if (power_control_reg[POS_IDLE]) begin
                    next_pwr_state = pwr_idle;  // [R2]
                end else begin
                    next_pwr_state = pwr_run;
                end
            end
            pwr_idle: begin
                if (int_enabled_pending) begin
                    next_pwr_state = pwr_run;  // [R21]
                end else if (power_control_reg[POS_POWERDOWN]) begin
                    next_pwr_state = pwr_down;
                end else begin
                    next_pwr_state = pwr_idle;
                end
            end
            pwr_down: begin
                next_pwr_state = ext_int_enabled_pending ? pwr_run : pwr_down;  // [R21]
            end
            default: next_pwr_state = pwr_run;
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            pwr_state <= pwr_run;  // [R21]
        end else begin
            pwr_state <= next_pwr_state;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_clk_run <= 1'b1;
            periph_clk_run <= 1'b1;
        end else begin
            cpu_clk_run <= (next_pwr_state == pwr_run);  // [R2]
            periph_clk_run <= (next_pwr_state != pwr_down);  // [R3]
        end
    end
    // Economy mode select sits in the top bits of the power management register.
    econ_divider u_econ (
        .clk(clk),
        .rst(rst),
        .mode(econ_mode_e'(power_mgmt_reg[POS_ECON_LO +: 2])),
        .tick(div_tick)
    );
    always_ff @(posedge clk) begin
        if (rst) begin
            econ_tick <= 1'b0;
        end else begin
            econ_tick <= div_tick && (pwr_state != pwr_down);  // [R1] [R3]
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            power_mgmt_reg <= RST_ZERO;  // [R5]
        end else if (sfr_write && sfr_addr == ADDR_POWER_MGMT) begin
            power_mgmt_reg <= write_value & MASK_POWER_MGMT;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            port4_chipsel_cfg <= RST_ZERO;
        end else if (sfr_write && sfr_addr == ADDR_PORT4_CHIPSEL_CFG) begin
            port4_chipsel_cfg <= write_value & MASK_PULLUP;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            baud_double <= 1'b0;
            frame_err_enable <= 1'b0;
            port0_pullup_enable <= 1'b0;
            onchip_xram_enable <= 1'b0;
        end else begin
            baud_double <= power_control_reg[POS_BAUD_DOUBLE];  // [R18]
            frame_err_enable <= power_control_reg[POS_FRAME_ERR_EN];  // [R19]
            port0_pullup_enable <= port4_chipsel_cfg[POS_PULLUP];  // [R17]
            onchip_xram_enable <= power_mgmt_reg[POS_XRAM_EN];  // [R5]
        end
    end
    // Only data moves are decoded here; scratchpad accesses never reach this path.
    assign hit_onchip = power_mgmt_reg[POS_XRAM_EN] && (move_addr <= XRAM_LAST);  // [R4] [R6] [R8]
    xram_store #(.DEPTH(XRAM_BYTES)) u_xram (
        .clk(clk),
        .wr(move_req && move_wr && hit_onchip && cpu_clk_run),  // [R4]
        .addr(move_addr[$clog2(XRAM_BYTES)-1:0]),
        .wdata(move_wdata),
        .rdata(xram_rdata)
    );
    always_ff @(posedge clk) begin
        if (rst) begin
            xram_rd_pending <= 1'b0;
            move_onchip_rdata <= RST_ZERO;
        end else begin
            xram_rd_pending <= move_req && !move_wr && hit_onchip;
            if (xram_rd_pending) begin
                move_onchip_rdata <= xram_rdata;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            move_onchip <= 1'b0;
            move_ext_req <= 1'b0;
            move_ext_wr <= 1'b0;
            move_ext_addr <= 16'h0000;
            move_ext_wdata <= RST_ZERO;
        end else begin
            move_onchip <= move_req && hit_onchip;  // [R6]
            move_ext_req <= move_req && !hit_onchip;  // [R5] [R6]
            move_ext_wr <= move_req && !hit_onchip && move_wr;
            if (move_req) begin
                move_ext_addr <= move_addr;
                move_ext_wdata <= move_wdata;
            end
        end
    end
    // Fetches always go to the separate 64 KB code space, never the data SRAM.
    always_ff @(posedge clk) begin
        if (rst) begin
            code_ext_req <= 1'b0;
            code_ext_addr <= 16'h0000;
        end else begin
            code_ext_req <= code_req;  // [R7] [R9]
            if (code_req) begin
                code_ext_addr <= code_addr;  // [R9]
            end
        end
    end

endmodule

// [verif/core_sfr_monitor.sv]
/*
 * Checker for the core SFR block: power modes, move routing, SFR reads.
 * Assumes the synchronous active-high reset; bound to the ports.
 */
`timescale 1ns/1ps
module core_sfr_monitor
    import core_sfr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // SFR access.
    input wire logic sfr_direct,
    input wire logic sfr_rd,
    input wire logic sfr_wr,
    input wire logic sfr_bit,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_bit_rdata,
    // Data moves.
    input wire logic move_req,
    input wire logic [15:0] move_addr,
    input wire logic move_onchip,
    input wire logic move_ext_req,
    input wire logic [15:0] move_ext_addr,
    // Power.
    input wire logic int_enabled_pending,
    input wire logic ext_int_enabled_pending,
    input wire logic cpu_clk_run,
    input wire logic periph_clk_run,
    input wire logic econ_tick,
    input wire logic onchip_xram_enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic rd_byte;
    assign rd_byte = sfr_rd && sfr_direct && !sfr_bit;

    sequence pc_wr(logic [1:0] v);
        sfr_wr && sfr_direct && !sfr_bit && sfr_addr == ADDR_POWER_CONTROL && sfr_wdata[1:0] == v;
    endsequence
    // The enable port lags its bit by a cycle.
    sequence lo_move;
        move_req && move_addr <= XRAM_LAST;
    endsequence

    idle_entry_a: assert property (pc_wr(2'b01) |-> ##[1:3] (!cpu_clk_run && periph_clk_run))
        else $error("idle entry wrong");
    down_entry_a: assert property (pc_wr(2'b10) |-> ##[1:3] (!cpu_clk_run && !periph_clk_run && !econ_tick))
        else $error("down entry wrong");
    idle_wake_a: assert property (!cpu_clk_run && periph_clk_run && int_enabled_pending |-> ##[1:3] cpu_clk_run)
        else $error("idle wake missing");
    down_wake_a: assert property (!periph_clk_run && ext_int_enabled_pending |-> ##[1:3] (periph_clk_run && cpu_clk_run))
        else $error("down wake missing");
    xram_off_a: assert property (lo_move ##1 !onchip_xram_enable |-> move_ext_req && !move_onchip && move_ext_addr == $past(move_addr))
        else $error("move not external");
    xram_hit_a: assert property (lo_move ##1 onchip_xram_enable |-> move_onchip && !move_ext_req)
        else $error("move missed sram");
    hi_move_a: assert property (move_req && move_addr > XRAM_LAST |=> move_ext_req && !move_onchip && move_ext_addr == $past(move_addr))
        else $error("high move not external");
    reset_clear_a: assert property (disable iff (1'b0) rst |=> !onchip_xram_enable)
        else $error("sram enable kept");
    unimpl_ones_a: assert property (rd_byte && sfr_addr >= 8'h88 && sfr_addr != ADDR_PORT4_CHIPSEL_CFG && sfr_addr != ADDR_POWER_MGMT |=> sfr_rdata == UNIMPL_READ)
        else $error("unmapped read wrong");
    bit_cap_a: assert property (sfr_rd && sfr_direct && sfr_bit && sfr_addr[2:0] != 3'h0 |=> sfr_bit_rdata)
        else $error("bit read not refused");
endmodule

bind core_sfr core_sfr_monitor u_core_sfr_monitor (.*);

// [verif/ext_bus_model.sv]
/*
 * External bus model: latches the last write sent off chip.
 * Assumes one-cycle requests.
 */
`timescale 1ns/1ps
module ext_bus_model (
    // Clock.
    input wire logic clk,
    // Bus from the block.
    input wire logic move_ext_req,
    input wire logic move_ext_wr,
    input wire logic [15:0] move_ext_addr,
    input wire logic [7:0] move_ext_wdata,
    // Last write seen.
    output logic [15:0] ext_addr,
    output logic [7:0] ext_data
);
    // Reads go unanswered: the block has no return path.
    always_ff @(posedge clk) begin
        if (move_ext_req && move_ext_wr) begin
            ext_addr <= move_ext_addr;
            ext_data <= move_ext_wdata;
        end
    end
endmodule

// [verif/core_sfr_tb.sv]
/*
 * Self-checking bench acting as the CPU core.
 * Assumes the bound checker and the bus model.
 */
`timescale 1ns/1ps
module core_sfr_tb
    import core_sfr_pkg::*;
;
    logic clk = 0, rst = 1, sfr_direct = 0, sfr_rd = 0, sfr_wr = 0, sfr_bit = 0, sfr_bit_val = 0;
    logic ptr_load = 0, ptr_inc = 0, ptr_dec = 0, stack_load = 0, move_req = 0, move_wr = 0;
    logic code_req = 0, int_enabled_pending = 0, ext_int_enabled_pending = 0;
    logic [2:0] sfr_bit_pos = 0;
    logic [7:0] sfr_addr = 0, sfr_wdata = 0, stack_load_val = 8'h3C, move_wdata = 0, rd8;
    logic [15:0] ptr_load_val = 16'hABCD, move_addr = 0, code_addr = 0;
    logic [7:0] sfr_rdata, stack_top, move_ext_wdata, move_onchip_rdata, ext_data;
    logic [15:0] active_pointer, move_ext_addr, code_ext_addr, ext_addr;
    logic sfr_bit_rdata, move_onchip, move_ext_req, move_ext_wr, code_ext_req, cpu_clk_run, rd1;
    logic periph_clk_run, econ_tick, baud_double, frame_err_enable, port0_pullup_enable;
    logic onchip_xram_enable;
    wire [15:0] runs = {14'h0, cpu_clk_run, periph_clk_run};
    int error_cnt = 0, total_checks = 0, ticks;
    logic [7:0] ra [12] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'hC4,
        8'hA2, 8'h88, 8'hFF};
    logic [7:0] re [12] = '{8'hFF, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'h3E,
        8'hFE, 8'hFF, 8'hFF};
    int dv [4] = '{1, 4, 64, 1024};

    core_sfr u_core_sfr (.*);
    ext_bus_model u_ext_bus_model (.*);

    always #25 clk = ~clk;

    task end_sim;
        if (error_cnt == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input string n, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Bit accesses: index in d[2:0], value in d[7].
    task acc(input logic dr, w, b, input logic [7:0] a, d);
        @(posedge clk);
        sfr_direct <= dr;
        sfr_wr <= w;
        sfr_rd <= !w;
        sfr_bit <= b;
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_bit_pos <= d[2:0];
        sfr_bit_val <= d[7];
        @(posedge clk);
        sfr_wr <= 0;
        sfr_rd <= 0;
        #1;
        rd8 = sfr_rdata;
        rd1 = sfr_bit_rdata;
    endtask

    task wr(input logic [7:0] a, d);
        acc(1, 1, 0, a, d);
    endtask

    task rchk(input string n, input logic [7:0] a, e);
        acc(1, 0, 0, a, 8'h00);
        chk(n, {8'h00, e}, {8'h00, rd8});
    endtask

    task cpu(input logic l, i, d, s);
        @(posedge clk);
        ptr_load <= l;
        ptr_inc <= i;
        ptr_dec <= d;
        stack_load <= s;
        @(posedge clk);
        {ptr_load, ptr_inc, ptr_dec, stack_load} <= 4'h0;
        cyc(2);
    endtask

    task mv(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        move_req <= 1;
        move_wr <= w;
        move_addr <= a;
        move_wdata <= d;
        @(posedge clk);
        move_req <= 0;
        #1;
    endtask

    task wake(input logic i, e);
        @(posedge clk);
        int_enabled_pending <= i;
        ext_int_enabled_pending <= e;
        @(posedge clk);
        int_enabled_pending <= 0;
        ext_int_enabled_pending <= 0;
        cyc(3);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_sim();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        for (int i = 0; i < 12; i++) rchk("reset read", ra[i], re[i]);
        wr(ADDR_POINTER0_LOW, 8'h11);
        wr(ADDR_POINTER0_HIGH, 8'h22);
        wr(ADDR_POINTER1_LOW, 8'h33);
        wr(ADDR_POINTER1_HIGH, 8'h44);
        cyc(2);
        chk("pair0", 16'h2211, active_pointer);
        wr(ADDR_POINTER_SELECT, 8'hFF);
        cyc(2);
        chk("pair1", 16'h4433, active_pointer);
        rchk("select", ADDR_POINTER_SELECT, 8'h01);
        cpu(0, 1, 0, 0);
        rchk("pair1 low", ADDR_POINTER1_LOW, 8'h34);
        cpu(1, 0, 0, 0);
        cpu(0, 0, 1, 0);
        chk("load dec", 16'hABCC, active_pointer);
        wr(ADDR_POINTER_SELECT, 8'h00);
        cyc(2);
        chk("back pair0", 16'h2211, active_pointer);
        cpu(0, 0, 0, 1);
        chk("stack load", 16'h003C, {8'h00, stack_top});
        wr(ADDR_STACK_TOP, 8'h5A);
        acc(1, 1, 1, ADDR_PORT0_LATCH, 8'h03);
        rchk("bit clear", ADDR_PORT0_LATCH, 8'hF7);
        acc(1, 1, 1, ADDR_STACK_TOP, 8'h80);
        acc(0, 1, 0, ADDR_STACK_TOP, 8'h99);
        rchk("stack kept", ADDR_STACK_TOP, 8'h5A);
        acc(1, 0, 1, ADDR_PORT0_LATCH, 8'h03);
        chk("bit read", 16'h0000, {15'h0, rd1});
        acc(1, 0, 1, ADDR_STACK_TOP, 8'h00);
        chk("bit refused", 16'h0001, {15'h0, rd1});
        wr(ADDR_POWER_CONTROL, 8'hCC);
        wr(ADDR_PORT4_CHIPSEL_CFG, 8'h01);
        cyc(2);
        chk("ctl bits", 16'h0007, {13'h0, baud_double, frame_err_enable, port0_pullup_enable});
        rchk("power ctl", ADDR_POWER_CONTROL, 8'hFC);
        mv(1, 16'h0100, 8'hA5);
        chk("ext low", 16'h0100, move_ext_req ? move_ext_addr : 16'hFFFF);
        wr(ADDR_POWER_MGMT, 8'h01);
        cyc(2);
        mv(1, 16'h03FF, 8'h5A);
        chk("onchip", 16'h0001, {15'h0, move_onchip});
        mv(0, 16'h03FF, 8'h00);
        cyc(1);
        chk("onchip data", 16'h005A, {8'h00, move_onchip_rdata});
        mv(1, 16'h0400, 8'hC3);
        cyc(1);
        chk("ext write", 16'h04C3, {ext_addr[15:8], ext_data});
        @(posedge clk);
        code_req <= 1;
        code_addr <= 16'h0100;
        @(posedge clk);
        code_req <= 0;
        #1;
        chk("code fetch", 16'h0100, code_ext_req ? code_ext_addr : 16'hFFFF);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_POWER_MGMT, {i[1:0], 6'h01});
            cyc(dv[i] + 4);
            ticks = 0;
            repeat (2 * dv[i]) begin
                @(posedge clk);
                #1;
                if (econ_tick === 1'b1) ticks++;
            end
            chk("econ ticks", 16'h0002, ticks[15:0]);
        end
        wr(ADDR_POWER_MGMT, 8'h01);
        wr(ADDR_POWER_CONTROL, 8'h01);
        cyc(4);
        chk("idle", 16'h0001, runs);
        wake(1, 0);
        chk("idle wake", 16'h0003, runs);
        rchk("idle cleared", ADDR_POWER_CONTROL, 8'h30);
        wr(ADDR_POWER_CONTROL, 8'h02);
        cyc(4);
        chk("down", 16'h0000, {13'h0, cpu_clk_run, periph_clk_run, econ_tick});
        wake(1, 0);
        chk("down held", 16'h0000, runs);
        wake(0, 1);
        chk("down wake", 16'h0003, runs);
        end_sim();
    end
endmodule
